// ==== hdl/dps_consts.svh ====
// Offsets, field positions, reset values and timing counts of the debug port register bank.
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
`define DPS_OFS_REVISION      4'h0
`define DPS_OFS_ERRSIG        4'h1
`define DPS_OFS_CTRL_A        4'h2
`define DPS_OFS_CTRL_B        4'h3
`define DPS_OFS_KEY_STATUS    4'h7
`define DPS_OFS_RESET_REQ     4'h8
`define DPS_OFS_CLK_SEL       4'h9
`define DPS_OFS_SYS_CTRL      4'ha
`define DPS_OFS_SYS_STATUS    4'hb
`define DPS_OFS_CRC_STATUS    4'hc
`define DPS_PHY_LAST_OFS      4'h3
`define DPS_BIT_BYTE_GAP      7
`define DPS_BIT_PARITY_IGNORE 5
`define DPS_BIT_TIMEOUT_OFF   4
`define DPS_BIT_REPLY_MUTE    3
`define DPS_CTRL_A_MASK       8'hbf
`define DPS_CTRL_B_MASK       8'h1c
`define DPS_CTRL_A_RESET      8'h00
`define DPS_CTRL_B_RESET      8'h00
`define DPS_CLK_SEL_RESET     2'h3
`define DPS_SYS_CTRL_RESET    2'h1
`define DPS_RESET_SIGNATURE   8'h59
`define DPS_ERR_NONE          3'h0
`define DPS_ERR_PARITY        3'h1
`define DPS_ERR_FRAME         3'h2
`define DPS_ERR_TIMEOUT       3'h3
`define DPS_ERR_CLOCK         3'h4
`define DPS_ERR_CONTENTION    3'h7
`define DPS_GUARD_OFF         3'h7
`define DPS_GUARD_MAX_CYCLES  128
`define DPS_TIMEOUT_CYCLES    65536
`define DPS_GAP_CHARS         2
`endif

// ==== hdl/dps_pkg.sv ====
// Types shared by the debug port register bank.
package dps_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dps_access_type;

  typedef struct packed {
    logic parity_err;
    logic frame_err;
    logic start_err;
    logic contention;
  } dps_line_err_type;

  typedef enum logic [1:0] {
    DPS_TX_IDLE  = 2'b00,
    DPS_TX_GUARD = 2'b01,
    DPS_TX_SEND  = 2'b11,
    DPS_TX_GAP   = 2'b10
  } dps_tx_state_type;
endpackage : dps_pkg

// ==== hdl/dps_tx_pacer.sv ====
// Transmit pacing: turnaround guard before a reply burst and byte gap between bytes.
`timescale 1ns/1ns
`default_nettype none
`include "dps_consts.svh"
module dps_tx_pacer #(
  parameter int CHAR_CYCLES = 12
) (
  input  wire logic       sys_clk,     // Port clock.
  input  wire logic       rstn,        // Asynchronous reset, active low.
  input  wire logic [2:0] guard_sel,   // Turnaround gap select code.
  input  wire logic       gap_en,      // Byte gap enable.
  input  wire logic       byte_req,    // A reply byte is waiting.
  input  wire logic       byte_last,   // The waiting byte ends the burst.
  output logic            byte_go      // Send the waiting byte now.
);
  localparam int GAP_CYCLES = `DPS_GAP_CHARS * CHAR_CYCLES;

  dps_pkg::dps_tx_state_type state_r;
  logic [7:0]                cnt_r;

  function automatic logic [7:0] guard_len(input logic [2:0] sel);
    guard_len = 8'(`DPS_GUARD_MAX_CYCLES >> sel);
  endfunction : guard_len

  assign byte_go = (state_r == dps_pkg::DPS_TX_SEND) && byte_req;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= dps_pkg::DPS_TX_IDLE;
      cnt_r   <= 8'h00;
    end else begin
      unique case (state_r)
        dps_pkg::DPS_TX_IDLE: begin
          if (byte_req) begin
            if (guard_sel == `DPS_GUARD_OFF) begin
              state_r <= dps_pkg::DPS_TX_SEND;
            end else begin
              state_r <= dps_pkg::DPS_TX_GUARD;
              cnt_r   <= guard_len(guard_sel) - 8'h01;
            end
          end
        end
        dps_pkg::DPS_TX_GUARD: begin
          if (cnt_r == 8'h00) begin
            state_r <= dps_pkg::DPS_TX_SEND;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        dps_pkg::DPS_TX_SEND: begin
          if (byte_req) begin
            if (byte_last) begin
              state_r <= dps_pkg::DPS_TX_IDLE;
            end else if (gap_en) begin
              state_r <= dps_pkg::DPS_TX_GAP;
              cnt_r   <= 8'(GAP_CYCLES - 1);
            end
          end
        end
        dps_pkg::DPS_TX_GAP: begin
          if (cnt_r == 8'h00) begin
            state_r <= dps_pkg::DPS_TX_SEND;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
      endcase
    end
  end

  AST_GAP_HOLDS: assert property (@(posedge sys_clk) disable iff (!rstn)
    (byte_go && !byte_last && gap_en) |=> !byte_go [*2])
    else $error("byte sent without byte gap");

  AST_GUARD_FIRST: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_r == dps_pkg::DPS_TX_IDLE && byte_req && guard_sel != `DPS_GUARD_OFF)
      |=> !byte_go [*2])
    else $error("first byte sent without turnaround guard");
endmodule : dps_tx_pacer
`default_nettype wire

// ==== hdl/dps_regbank.sv ====
// Register bank of the single-wire debug port: status, control, reset request and error capture.
`timescale 1ns/1ns
`default_nettype none
`include "dps_consts.svh"
module dps_regbank #(
  parameter logic [3:0] REVISION       = 4'h3,                // Arbitrary value.
  parameter int         TIMEOUT_CYCLES = `DPS_TIMEOUT_CYCLES, // Bus-side response limit.
  parameter int         CHAR_CYCLES    = 12                   // Port clocks per character.
) (
  input  wire logic                     sys_clk,        // Port clock, 100 MHz.
  input  wire logic                     rstn,           // Asynchronous reset, active low.
  input  wire dps_pkg::dps_access_type  acc,            // Debugger register instruction.
  output logic [7:0]                    rdata,          // Read data, registered.
  input  wire dps_pkg::dps_line_err_type line_err,      // One-cycle line error pulses.
  input  wire logic                     bus_req,        // Bus-side request in flight start.
  input  wire logic                     bus_resp,       // Bus-side answered.
  input  wire logic                     sleep_pin,      // System in idle or deeper sleep.
  input  wire logic                     sys_in_reset,   // System domain held in reset.
  input  wire logic                     reply_req,      // Response signature waiting.
  input  wire logic                     byte_req,       // Reply data byte waiting.
  input  wire logic                     byte_last,      // Waiting byte ends the burst.
  output logic                          byte_go,        // Send the waiting byte.
  output logic                          reply_go,       // Send the response signature.
  output logic                          reply_drop,     // Drop the response signature.
  output logic                          timeout_err,    // Bus-side time-out pulse.
  output logic                          sys_clk_hold,   // Keep the system clock running.
  output logic                          sys_reset_req,  // Hold system in reset.
  output logic [1:0]                    port_clk_sel    // Port clock select.
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  logic [7:0]    ctrl_a_r;
  logic [7:0]    ctrl_b_r;
  logic [2:0]    errsig_r;
  logic          rst_req_r;
  logic [1:0]    clk_sel_r;
  logic [1:0]    sys_ctrl_r;
  logic          sleep_s1_r;
  logic          sleep_s2_r;
  logic          rstin_s1_r;
  logic          rstin_s2_r;
  logic          wait_r;
  logic [TW-1:0] to_cnt_r;
  logic [2:0]    err_code;
  logic          err_evt;
  logic          rd_errsig;
  logic [7:0]    rd_nxt;

  function automatic logic is_phy(input logic [3:0] a);
    is_phy = (a <= `DPS_PHY_LAST_OFS);
  endfunction : is_phy

  function automatic logic hit(input dps_pkg::dps_access_type x, input logic [3:0] a);
    hit = x.addr == a;
  endfunction : hit

  // Sleep and reset inputs come from the system domain.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
      rstin_s1_r <= 1'b0;
      rstin_s2_r <= 1'b0;
    end else begin
      sleep_s1_r <= sleep_pin;
      sleep_s2_r <= sleep_s1_r;
      rstin_s1_r <= sys_in_reset;
      rstin_s2_r <= rstin_s1_r;
    end
  end

  // Physical-layer control registers.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_r <= `DPS_CTRL_A_RESET;
      ctrl_b_r <= `DPS_CTRL_B_RESET;
    end else if (acc.wr && is_phy(acc.addr)) begin
      if (hit(acc, `DPS_OFS_CTRL_A)) begin
        ctrl_a_r <= acc.wdata & `DPS_CTRL_A_MASK;
      end
      if (hit(acc, `DPS_OFS_CTRL_B)) begin
        ctrl_b_r <= acc.wdata & `DPS_CTRL_B_MASK;
      end
    end
  end

  // Bus-side registers: reset request, clock select, system control.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_req_r  <= 1'b0;
      clk_sel_r  <= `DPS_CLK_SEL_RESET;
      sys_ctrl_r <= `DPS_SYS_CTRL_RESET;
    end else if (acc.wr && !is_phy(acc.addr)) begin
      if (hit(acc, `DPS_OFS_RESET_REQ)) begin
        rst_req_r <= (acc.wdata == `DPS_RESET_SIGNATURE);
      end
      if (hit(acc, `DPS_OFS_CLK_SEL)) begin
        clk_sel_r <= acc.wdata[1:0];
      end
      if (hit(acc, `DPS_OFS_SYS_CTRL)) begin
        sys_ctrl_r <= acc.wdata[1:0];
      end
    end
  end

  assign sys_clk_hold  = sys_ctrl_r[0];
  assign sys_reset_req = rst_req_r;
  assign port_clk_sel  = clk_sel_r;

  // Bus-side response watchdog.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_r   <= 1'b0;
      to_cnt_r <= '0;
    end else if (bus_resp || timeout_err) begin
      wait_r   <= 1'b0;
      to_cnt_r <= '0;
    end else if (bus_req) begin
      wait_r   <= 1'b1;
      to_cnt_r <= '0;
    end else if (wait_r) begin
      to_cnt_r <= to_cnt_r + TW'(1);
    end
  end

  assign timeout_err = wait_r && !bus_resp && !ctrl_a_r[`DPS_BIT_TIMEOUT_OFF]
                       && (to_cnt_r == TW'(TIMEOUT_CYCLES - 1));

  // Error priority: contention, clock recovery, frame, parity, time-out.
  always_comb begin
    err_evt  = 1'b1;
    err_code = `DPS_ERR_NONE;
    if (line_err.contention) begin
      err_code = `DPS_ERR_CONTENTION;
    end else if (line_err.start_err) begin
      err_code = `DPS_ERR_CLOCK;
    end else if (line_err.frame_err) begin
      err_code = `DPS_ERR_FRAME;
    end else if (line_err.parity_err && !ctrl_a_r[`DPS_BIT_PARITY_IGNORE]) begin
      err_code = `DPS_ERR_PARITY;
    end else if (timeout_err) begin
      err_code = `DPS_ERR_TIMEOUT;
    end else begin
      err_evt = 1'b0;
    end
  end

  assign rd_errsig = acc.rd && hit(acc, `DPS_OFS_ERRSIG);

  // A new error wins over the clear of a read in the same cycle.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      errsig_r <= `DPS_ERR_NONE;
    end else if (err_evt) begin
      errsig_r <= err_code;
    end else if (rd_errsig) begin
      errsig_r <= `DPS_ERR_NONE;
    end
  end

  // Read multiplexer; only the debugger access port reaches it.
  always_comb begin
    rd_nxt = 8'h00;
    unique case (acc.addr)
      `DPS_OFS_REVISION:   rd_nxt = {REVISION, 4'h0};
      `DPS_OFS_ERRSIG:     rd_nxt = {5'h00, errsig_r};
      `DPS_OFS_CTRL_A:     rd_nxt = ctrl_a_r;
      `DPS_OFS_CTRL_B:     rd_nxt = ctrl_b_r;
      `DPS_OFS_RESET_REQ:  rd_nxt = {7'h00, rst_req_r};
      `DPS_OFS_CLK_SEL:    rd_nxt = {6'h00, clk_sel_r};
      `DPS_OFS_SYS_CTRL:   rd_nxt = {6'h00, sys_ctrl_r};
      `DPS_OFS_SYS_STATUS: rd_nxt = {2'h0, rstin_s2_r | rst_req_r, sleep_s2_r, 4'h0};
      default:             rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (acc.rd) begin
      rdata <= rd_nxt;
    end
  end

  // Response signatures are passed or dropped.
  assign reply_go   = reply_req && !ctrl_a_r[`DPS_BIT_REPLY_MUTE];
  assign reply_drop = reply_req && ctrl_a_r[`DPS_BIT_REPLY_MUTE];

  dps_tx_pacer #(
    .CHAR_CYCLES(CHAR_CYCLES)
  ) dps_tx_pacer_inst (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .guard_sel(ctrl_a_r[2:0]),
    .gap_en   (ctrl_a_r[`DPS_BIT_BYTE_GAP]),
    .byte_req (byte_req),
    .byte_last(byte_last),
    .byte_go  (byte_go)
  );

  sequence s_errsig_read;
    rd_errsig && !err_evt;
  endsequence

  AST_ERR_CLEAR_ON_READ: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_errsig_read |=> errsig_r == 3'h0)
    else $error("error signature not cleared by read");

  AST_ERR_LOAD: assert property (@(posedge sys_clk) disable iff (!rstn)
    err_evt |=> errsig_r == $past(err_code))
    else $error("error signature not loaded");

  AST_NO_RSVD_CODE: assert property (@(posedge sys_clk) disable iff (!rstn)
    errsig_r != 3'h5 && errsig_r != 3'h6)
    else $error("reserved error code");

  AST_PARITY_IGNORED: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ctrl_a_r[5] && line_err == 4'b1000) |-> err_code != `DPS_ERR_PARITY)
    else $error("parity error raised while ignored");

  AST_TIMEOUT_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctrl_a_r[4] |-> !timeout_err)
    else $error("time-out while disabled");

  AST_RESET_SIG: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc.wr && acc.addr == 4'h8) |=> sys_reset_req == ($past(acc.wdata) == 8'h59))
    else $error("reset request mismatch");

  AST_MUTE: assert property (@(posedge sys_clk) disable iff (!rstn)
    ctrl_a_r[3] |-> !reply_go)
    else $error("response sent while muted");

  AST_RSVD_READ: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc.rd && acc.addr inside {4'h4, 4'h5, 4'h6, 4'hd, 4'he, 4'hf}) |=> rdata == 8'h00)
    else $error("reserved offset read nonzero");

  AST_REVISION: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc.rd && acc.addr == 4'h0) |=> rdata[3:0] == 4'h0 && rdata[7:4] == REVISION)
    else $error("revision register wrong");

  AST_SLEEP_FLAG: assert property (@(posedge sys_clk) disable iff (!rstn)
    sleep_pin [*3] |-> sleep_s2_r)
    else $error("asleep flag lags");

  // Register writes that the reset request and clock hold checks start from.
  sequence s_reset_sig_write;
    acc.wr && acc.addr == `DPS_OFS_RESET_REQ && acc.wdata == `DPS_RESET_SIGNATURE;
  endsequence

  sequence s_reset_other_write;
    acc.wr && acc.addr == `DPS_OFS_RESET_REQ && acc.wdata != `DPS_RESET_SIGNATURE;
  endsequence

  sequence s_hold_write;
    acc.wr && acc.addr == `DPS_OFS_SYS_CTRL;
  endsequence

  AST_RESET_HELD: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_reset_sig_write ##1 !(acc.wr && acc.addr == `DPS_OFS_RESET_REQ) |=> sys_reset_req)
    else $error("system reset request not held");

  AST_RESET_RELEASED: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_reset_other_write |=> !sys_reset_req)
    else $error("system reset request not released");

  AST_HOLD_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_hold_write |=> sys_clk_hold == $past(acc.wdata[0]))
    else $error("clock hold does not follow write");

  AST_CLK_SEL_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc.wr && acc.addr == `DPS_OFS_CLK_SEL) |=> port_clk_sel == $past(acc.wdata[1:0]))
    else $error("clock select does not follow write");

  AST_CONTENTION_CODE: assert property (@(posedge sys_clk) disable iff (!rstn)
    line_err.contention |=> errsig_r == `DPS_ERR_CONTENTION)
    else $error("contention not reported as seven");

  AST_START_CODE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (line_err.start_err && !line_err.contention) |=> errsig_r == `DPS_ERR_CLOCK)
    else $error("start bit error not reported as four");

  AST_FRAME_CODE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (line_err == 4'b0100) |=> errsig_r == `DPS_ERR_FRAME)
    else $error("frame error not reported as two");

  AST_PARITY_CODE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (line_err == 4'b1000 && !ctrl_a_r[5] && !timeout_err) |=> errsig_r == `DPS_ERR_PARITY)
    else $error("parity error not reported as one");

  AST_TIMEOUT_CODE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (timeout_err && line_err == 4'b0000) |=> errsig_r == `DPS_ERR_TIMEOUT)
    else $error("time-out not reported as three");

  AST_NO_EARLY_TIMEOUT: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus_req |=> !timeout_err [*8])
    else $error("time-out right after request");

  AST_TIMEOUT_PULSE: assert property (@(posedge sys_clk) disable iff (!rstn)
    timeout_err |=> !timeout_err)
    else $error("time-out longer than one cycle");

  AST_REPLY_EXCLUSIVE: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(reply_go && reply_drop))
    else $error("response both sent and dropped");

  AST_REPLY_ACCOUNTED: assert property (@(posedge sys_clk) disable iff (!rstn)
    reply_req |-> (reply_go || reply_drop))
    else $error("response neither sent nor dropped");

  AST_RDATA_HOLDS: assert property (@(posedge sys_clk) disable iff (!rstn)
    !acc.rd |=> $stable(rdata))
    else $error("read data changed without a read");

  AST_ERRSIG_READ_DATA: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd_errsig |=> rdata == {5'h00, $past(errsig_r)})
    else $error("error signature read returned wrong value");

  AST_CTRL_A_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (acc.wr && acc.addr == `DPS_OFS_CTRL_A) |=> !ctrl_a_r[6] && ctrl_a_r[5] == $past(acc.wdata[5]))
    else $error("control A write wrong");

  AST_ERRSIG_QUIET: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!err_evt && !rd_errsig) |=> $stable(errsig_r))
    else $error("error signature changed without cause");
endmodule : dps_regbank
`default_nettype wire

// ==== tb/dps_debugger.sv ====
// Debugger model that issues register instructions to the port register bank.
`timescale 1ns/1ns
`default_nettype none
module dps_debugger (
  input  wire logic                    sys_clk, // Port clock.
  output var dps_pkg::dps_access_type  acc      // Register instruction to the bank.
);
  initial acc = '0;

  // One instruction, held for one edge; idle fields then show inverted values, not stale ones.
  task automatic access(input logic is_wr, input logic [3:0] addr, input logic [7:0] wdata);
    @(posedge sys_clk);
    #1;
    acc = {is_wr, ~is_wr, addr, wdata};
    @(posedge sys_clk);
    #1;
    acc = {1'b0, 1'b0, ~addr, ~wdata};
  endtask : access
endmodule : dps_debugger
`default_nettype wire

// ==== tb/debug_port_config_status_bench.sv ====
// Self-checking bench for the debug port register bank.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (e)); end end
module debug_port_config_status_bench;
  localparam logic [3:0] REV = 4'h5; // Arbitrary revision value.
  localparam int         TMO = 16;
  localparam int         CHR = 4;
  logic                         sys_clk, rstn, bus_req, bus_resp, sleep_pin, sys_in_reset;
  logic                         reply_req, byte_req, byte_last;
  logic                         byte_go, reply_go, reply_drop, timeout_err;
  logic                         sys_clk_hold, sys_reset_req;
  logic [1:0]                   port_clk_sel;
  logic [7:0]                   rdata;
  dps_pkg::dps_access_type      acc;
  dps_pkg::dps_line_err_type    line_err;
  int                           bad_count, checks_done;

  dps_debugger dps_debugger_inst (.sys_clk(sys_clk), .acc(acc));
  dps_regbank #(.REVISION(REV), .TIMEOUT_CYCLES(TMO), .CHAR_CYCLES(CHR)) dps_regbank_inst (
    .sys_clk(sys_clk), .rstn(rstn), .acc(acc), .rdata(rdata), .line_err(line_err),
    .bus_req(bus_req), .bus_resp(bus_resp), .sleep_pin(sleep_pin),
    .sys_in_reset(sys_in_reset), .reply_req(reply_req), .byte_req(byte_req),
    .byte_last(byte_last), .byte_go(byte_go), .reply_go(reply_go), .reply_drop(reply_drop),
    .timeout_err(timeout_err), .sys_clk_hold(sys_clk_hold), .sys_reset_req(sys_reset_req),
    .port_clk_sel(port_clk_sel));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    dps_debugger_inst.access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    dps_debugger_inst.access(1'b0, a, 8'h00);
    `CHK(rdata, e)
  endtask : rd

  task automatic pulse_err(input logic [3:0] v);
    line_err = dps_pkg::dps_line_err_type'(v);
    tick();
    line_err = '0;
  endtask : pulse_err

  task automatic wait_go(output int n);
    n = 0;
    while (byte_go !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    if (n == 300) begin
      `CHK(1'b0, 1'b1)
      stop_test();
    end
    tick();
  endtask : wait_go

  task automatic check_reset_values();
    rd(4'h0, {REV, 4'h0});
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h9, 8'h03);
    rd(4'ha, 8'h01);
    `CHK(sys_clk_hold, 1'b1)
    for (int a = 4; a < 7; a++) rd(4'(a), 8'h00);
  endtask : check_reset_values

  task automatic check_write_access();
    wr(4'h0, 8'hff);
    rd(4'h0, {REV, 4'h0});
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00);
    wr(4'h2, 8'hff);
    rd(4'h2, 8'hbf);
    wr(4'h3, 8'hff);
    rd(4'h3, 8'h1c);
    wr(4'h2, 8'h00);
    wr(4'ha, 8'h00);
    `CHK(sys_clk_hold, 1'b0)
    wr(4'ha, 8'h01);
    `CHK(sys_clk_hold, 1'b1)
  endtask : check_write_access

  task automatic check_error_codes();
    logic [3:0] srcs [4] = '{4'b1000, 4'b0100, 4'b0010, 4'b0001};
    logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h04, 8'h07};
    for (int i = 0; i < 4; i++) begin
      pulse_err(srcs[i]);
      rd(4'h1, codes[i]);
      rd(4'h1, 8'h00);
    end
    pulse_err(4'b1000);
    pulse_err(4'b0001);
    rd(4'h1, 8'h07);
    pulse_err(4'b0100);
    fork
      rd(4'h1, 8'h02);
      begin
        tick();
        pulse_err(4'b0001);
      end
    join
    rd(4'h1, 8'h07);
    wr(4'h2, 8'h20);
    pulse_err(4'b1000);
    rd(4'h1, 8'h00);
    wr(4'h2, 8'h00);
  endtask : check_error_codes

  task automatic check_timeout(input logic off, input logic answer, input int exp_seen);
    int seen;
    int at;
    seen = 0;
    at = 0;
    wr(4'h2, off ? 8'h10 : 8'h00);
    bus_req = 1'b1;
    tick();
    bus_req = 1'b0;
    for (int i = 1; i < 40; i++) begin
      bus_resp = answer && i == 3;
      if (timeout_err === 1'b1) begin
        seen++;
        at = i;
      end
      tick();
    end
    bus_resp = 1'b0;
    `CHK(seen, exp_seen)
    if (exp_seen == 1) `CHK((at >= TMO - 2 && at <= TMO + 1), 1'b1)
    rd(4'h1, exp_seen == 1 ? 8'h03 : 8'h00);
    wr(4'h2, 8'h00);
  endtask : check_timeout

  task automatic check_reply_mute();
    reply_req = 1'b1;
    tick();
    `CHK({reply_go, reply_drop}, 2'b10)
    wr(4'h2, 8'h08);
    `CHK({reply_go, reply_drop}, 2'b01)
    reply_req = 1'b0;
    wr(4'h2, 8'h00);
  endtask : check_reply_mute

  task automatic check_reset_request();
    wr(4'h9, 8'h01);
    `CHK(port_clk_sel, 2'h1)
    wr(4'h8, 8'h59);
    `CHK(sys_reset_req, 1'b1)
    rd(4'h8, 8'h01);
    rd(4'hb, 8'h20);
    rd(4'h9, 8'h01);
    wr(4'h8, 8'h58);
    `CHK(sys_reset_req, 1'b0)
    rd(4'h8, 8'h00);
    wr(4'h9, 8'h03);
  endtask : check_reset_request

  task automatic check_sleep_status();
    sleep_pin = 1'b1;
    repeat (3) tick();
    rd(4'hb, 8'h10);
    sleep_pin = 1'b0;
    sys_in_reset = 1'b1;
    repeat (3) tick();
    rd(4'hb, 8'h20);
    sys_in_reset = 1'b0;
    repeat (3) tick();
    rd(4'hb, 8'h00);
  endtask : check_sleep_status

  task automatic check_pacing();
    int n;
    int g;
    byte_last = 1'b1;
    for (int c = 0; c < 8; c++) begin
      g = (c == 7) ? 0 : (128 >> c);
      wr(4'h2, 8'(c));
      byte_req = 1'b1;
      wait_go(n);
      byte_req = 1'b0;
      `CHK((n + 1 >= g && n <= g + 2), 1'b1)
      repeat (2) tick();
    end
    wr(4'h2, 8'h86);
    byte_last = 1'b0;
    byte_req = 1'b1;
    wait_go(n);
    `CHK((n + 1 >= 2 && n <= 4), 1'b1)
    byte_last = 1'b1;
    wait_go(n);
    `CHK((n + 1 >= 2 * CHR && n <= 2 * CHR + 2), 1'b1)
    byte_req = 1'b0;
    wr(4'h2, 8'h00);
  endtask : check_pacing

  task automatic stop_test();
    $display("Checks: %0d, mismatches: %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial begin
    {rstn, bus_req, bus_resp, sleep_pin, sys_in_reset} = '0;
    {reply_req, byte_req, byte_last} = '0;
    line_err = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (10) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    check_reset_values();
    check_write_access();
    check_error_codes();
    check_timeout(1'b0, 1'b0, 1);
    check_timeout(1'b1, 1'b0, 0);
    check_timeout(1'b0, 1'b1, 0);
    check_reply_mute();
    check_reset_request();
    check_sleep_status();
    check_pacing();
    stop_test();
  end
endmodule : debug_port_config_status_bench
`default_nettype wire
